/* File: rtl/lb_input_qual.sv */
// One table input qualifier: level or edge detection
`timescale 1ns/100ps
`default_nettype none
module lb_input_qual (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic level_in,
    input wire logic [2:0] mode_in,
    output logic hit_out
);

    // ----------------------------------------------------------------
    // Previous sample for edge detection
    // ----------------------------------------------------------------
    logic prev; // Level one cycle ago
    logic next_prev; // Next previous sample

    // Next value is just the current level
    always_comb begin
        next_prev = level_in;
    end

    // Register previous level
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

    // Qualified result; an edge holds true for exactly one cycle
    always_comb begin
        case (mode_in)
            lb_pkg::LB_Q_ACTIVE_LOW_LEVEL: hit_out = ~level_in;
            lb_pkg::LB_Q_ACTIVE_HIGH_LEVEL: hit_out = level_in;
            lb_pkg::LB_Q_FALLING_EDGE: hit_out = prev & ~level_in;
            lb_pkg::LB_Q_RISING_EDGE: hit_out = ~prev & level_in;
            lb_pkg::LB_Q_EITHER_EDGE: hit_out = prev ^ level_in;
            default: hit_out = 1'b0; // Unused codes never fire
        endcase
    end

endmodule : lb_input_qual
`default_nettype wire

/* File: rtl/lb_logic_block.sv */
// Two programmable lookup-table logic blocks with an APB register slave
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lb_regs.svh"
module lb_logic_block (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [3:0] line_in,
    input wire logic [3:0] user_output_in,
    input wire logic [1:0] counter_start_in,
    input wire logic [1:0] counter_end_in,
    input wire logic exposure_start_in,
    input wire logic exposure_end_in,
    input wire logic frame_trigger_wait_in,
    input wire logic acquisition_active_in,
    output logic [1:0] logic_block_out
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Table lookup: row index is {in2,in1,in0}
    function automatic logic lut_eval(input logic [7:0] table_bits,
                                      input logic [2:0] row);
        lut_eval = table_bits[row];
    endfunction : lut_eval

    // Known address check
    function automatic logic addr_ok(input logic [7:0] addr);
        addr_ok = (addr == `LB_OFS_SELECT) ||
                  (addr == `LB_OFS_INPUT_CFG) ||
                  (addr == `LB_OFS_ROW_BIT) ||
                  (addr == `LB_OFS_TABLE_WORD) ||
                  (addr == `LB_OFS_STATUS);
    endfunction : addr_ok

    // ----------------------------------------------------------------
    // Pin synchronisers for the external lines
    // ----------------------------------------------------------------
    logic [3:0] line_meta; // First stage, read only by second
    logic [3:0] line_sync; // Safe line levels
    logic [3:0] next_line_meta; // Next first stage
    logic [3:0] next_line_sync; // Next second stage

    // Shift the lines along the chain
    always_comb begin
        next_line_meta = line_in;
        next_line_sync = line_meta;
    end

    // Register the chain
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            line_meta <= 4'h0;
            line_sync <= 4'h0;
        end else begin
            line_meta <= next_line_meta;
            line_sync <= next_line_sync;
        end
    end

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    logic block_select; // Block being configured
    logic table_select; // 0 value table, 1 enable table
    logic [1:0] input_slot_select; // Input slot being configured
    logic [2:0] truth_row_pointer; // Row for single-bit writes
    logic [7:0] value_table [`LB_NUM_BLOCKS]; // Value truth tables
    logic [7:0] enable_table [`LB_NUM_BLOCKS]; // Enable truth tables
    logic [4:0] src_sel [`LB_NUM_BLOCKS][`LB_NUM_INPUTS]; // Shared sources
    logic [2:0] qual_sel [`LB_NUM_BLOCKS][`LB_NUM_INPUTS]; // Qualifiers
    logic next_block_select;
    logic next_table_select;
    logic [1:0] next_input_slot_select;
    logic [2:0] next_truth_row_pointer;
    logic [7:0] next_value_table [`LB_NUM_BLOCKS];
    logic [7:0] next_enable_table [`LB_NUM_BLOCKS];
    logic [4:0] next_src_sel [`LB_NUM_BLOCKS][`LB_NUM_INPUTS];
    logic [2:0] next_qual_sel [`LB_NUM_BLOCKS][`LB_NUM_INPUTS];
    logic wr_fire; // Completing write this edge
    logic [7:0] sel_table; // Table picked by both selectors

    assign wr_fire = psel_in & penable_in & pready_out & pwrite_in;

    // Selected table for row and word read-back
    always_comb begin
        if (table_select) begin
            sel_table = enable_table[block_select];
        end else begin
            sel_table = value_table[block_select];
        end
    end

    // Register writes update the selectors and the selected entries
    always_comb begin
        next_block_select = block_select;
        next_table_select = table_select;
        next_input_slot_select = input_slot_select;
        next_truth_row_pointer = truth_row_pointer;
        next_value_table = value_table;
        next_enable_table = enable_table;
        next_src_sel = src_sel;
        next_qual_sel = qual_sel;
        if (wr_fire && !pslverr_out) begin
            case (paddr_in)
                `LB_OFS_SELECT: begin
                    next_block_select = pwdata_in[`LB_SEL_BLOCK_BIT];
                    next_table_select = pwdata_in[`LB_SEL_TABLE_BIT];
                    next_input_slot_select =
                        pwdata_in[`LB_SEL_SLOT_MSB:`LB_SEL_SLOT_LSB];
                    next_truth_row_pointer =
                        pwdata_in[`LB_SEL_ROW_MSB:`LB_SEL_ROW_LSB];
                end
                `LB_OFS_INPUT_CFG: begin
                    // One slot store per block, whatever table is picked
                    if (input_slot_select < 2'(`LB_NUM_INPUTS)) begin
                        next_src_sel[block_select][input_slot_select] =
                            pwdata_in[`LB_CFG_SRC_MSB:`LB_CFG_SRC_LSB];
                        next_qual_sel[block_select][input_slot_select] =
                            pwdata_in[`LB_CFG_QUAL_MSB:`LB_CFG_QUAL_LSB];
                    end
                end
                `LB_OFS_ROW_BIT: begin
                    // Single row update at the row pointer
                    if (table_select) begin
                        next_enable_table[block_select][truth_row_pointer] =
                            pwdata_in[0];
                    end else begin
                        next_value_table[block_select][truth_row_pointer] =
                            pwdata_in[0];
                    end
                end
                `LB_OFS_TABLE_WORD: begin
                    // Whole eight-row word
                    if (table_select) begin
                        next_enable_table[block_select] = pwdata_in[7:0];
                    end else begin
                        next_value_table[block_select] = pwdata_in[7:0];
                    end
                end
                default: begin
                    // Status is read-only
                end
            endcase
        end
    end

    // Register the configuration
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            block_select <= 1'b0;
            table_select <= 1'b0;
            input_slot_select <= 2'h0;
            truth_row_pointer <= 3'h0;
            for (int b = 0; b < `LB_NUM_BLOCKS; b++) begin
                value_table[b] <= `LB_TABLE_RESET;
                enable_table[b] <= `LB_TABLE_RESET;
                for (int i = 0; i < `LB_NUM_INPUTS; i++) begin
                    src_sel[b][i] <= lb_pkg::LB_SRC_ZERO;
                    qual_sel[b][i] <= lb_pkg::LB_Q_ACTIVE_HIGH_LEVEL;
                end
            end
        end else begin
            block_select <= next_block_select;
            table_select <= next_table_select;
            input_slot_select <= next_input_slot_select;
            truth_row_pointer <= next_truth_row_pointer;
            value_table <= next_value_table;
            enable_table <= next_enable_table;
            src_sel <= next_src_sel;
            qual_sel <= next_qual_sel;
        end
    end

    // ----------------------------------------------------------------
    // Source selection, qualification and lookup
    // ----------------------------------------------------------------
    logic [`LB_NUM_SOURCES-1:0] src_vec; // All sources by choice code
    logic [2:0] qual_hit [`LB_NUM_BLOCKS]; // Qualified inputs per block
    logic [1:0] next_logic_block_out; // Next output flip-flops

    // Bit n of the vector is source choice n
    assign src_vec = {acquisition_active_in, frame_trigger_wait_in,
                      exposure_end_in, exposure_start_in, logic_block_out,
                      counter_end_in, counter_start_in, user_output_in,
                      line_sync, 1'b0};

    // One qualifier per block input, shared by both tables
    for (genvar gb = 0; gb < `LB_NUM_BLOCKS; gb++) begin : g_blk
        for (genvar gi = 0; gi < `LB_NUM_INPUTS; gi++) begin : g_in
            logic picked; // Chosen raw source
            assign picked = (src_sel[gb][gi] < 5'(`LB_NUM_SOURCES)) ?
                            src_vec[src_sel[gb][gi]] : 1'b0;
            lb_input_qual u_qual (
                .clock_in(clock_in),
                .rst_n_in(rst_n_in),
                .level_in(picked),
                .mode_in(qual_sel[gb][gi]),
                .hit_out(qual_hit[gb][gi])
            );
        end
    end

    // Output flip-flop: load value table only when enable table is true
    always_comb begin
        next_logic_block_out = logic_block_out;
        for (int b = 0; b < `LB_NUM_BLOCKS; b++) begin
            // All-ones enable table loads every cycle, i.e. pass-through
            if (lut_eval(enable_table[b], qual_hit[b])) begin
                next_logic_block_out[b] =
                    lut_eval(value_table[b], qual_hit[b]);
            end
        end
    end

    // Register the block outputs, low from reset
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            logic_block_out <= 2'h0;
        end else begin
            logic_block_out <= next_logic_block_out;
        end
    end

    // ----------------------------------------------------------------
    // APB answer: one wait state, registered read data
    // ----------------------------------------------------------------
    logic [31:0] next_prdata; // Next read data
    logic next_pready; // Next ready
    logic next_pslverr; // Next error

    // Ready rises in the second access cycle, then drops
    always_comb begin
        next_pready = psel_in & penable_in & ~pready_out;
        next_pslverr = 1'b0;
        next_prdata = 32'h0;
        if (next_pready) begin
            next_pslverr = ~addr_ok(paddr_in);
            if (!pwrite_in) begin
                case (paddr_in)
                    `LB_OFS_SELECT: begin
                        next_prdata = {25'h0, truth_row_pointer,
                                       input_slot_select, table_select,
                                       block_select};
                    end
                    `LB_OFS_INPUT_CFG: begin
                        if (input_slot_select < 2'(`LB_NUM_INPUTS)) begin
                            next_prdata = {21'h0,
                                qual_sel[block_select][input_slot_select],
                                3'h0,
                                src_sel[block_select][input_slot_select]};
                        end
                    end
                    `LB_OFS_ROW_BIT: begin
                        next_prdata = {31'h0, sel_table[truth_row_pointer]};
                    end
                    `LB_OFS_TABLE_WORD: next_prdata = {24'h0, sel_table};
                    `LB_OFS_STATUS: next_prdata = {30'h0, logic_block_out};
                    default: next_prdata = 32'h0; // Unmapped reads zero
                endcase
            end
        end
    end

    // Register the bus answer
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= next_pready;
            pslverr_out <= next_pslverr;
            prdata_out <= next_prdata;
        end
    end

endmodule : lb_logic_block
`default_nettype wire

/* File: rtl/lb_pkg.sv */
// Types shared by the logic block files
package lb_pkg;

    // ----------------------------------------------------------------
    // Input source choices
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        LB_SRC_ZERO = 5'h00,
        LB_SRC_LINE0 = 5'h01,
        LB_SRC_LINE1 = 5'h02,
        LB_SRC_LINE2 = 5'h03,
        LB_SRC_LINE3 = 5'h04,
        LB_SRC_USER0 = 5'h05,
        LB_SRC_USER1 = 5'h06,
        LB_SRC_USER2 = 5'h07,
        LB_SRC_USER3 = 5'h08,
        LB_SRC_CNT0_START = 5'h09,
        LB_SRC_CNT1_START = 5'h0a,
        LB_SRC_CNT0_END = 5'h0b,
        LB_SRC_CNT1_END = 5'h0c,
        LB_SRC_BLOCK0 = 5'h0d,
        LB_SRC_BLOCK1 = 5'h0e,
        LB_SRC_EXPOSURE_START = 5'h0f,
        LB_SRC_EXPOSURE_END = 5'h10,
        LB_SRC_FRAME_TRIG_WAIT = 5'h11,
        LB_SRC_ACQ_ACTIVE = 5'h12
    } lb_src_t;

    // ----------------------------------------------------------------
    // Input qualifiers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LB_Q_ACTIVE_LOW_LEVEL = 3'h0,
        LB_Q_ACTIVE_HIGH_LEVEL = 3'h1,
        LB_Q_FALLING_EDGE = 3'h2,
        LB_Q_RISING_EDGE = 3'h3,
        LB_Q_EITHER_EDGE = 3'h4
    } lb_qual_t;

endpackage : lb_pkg

/* File: rtl/lb_regs.svh */
// Register offsets, field positions, reset values for the logic block
// Notes on behaviour
// - Value table feeds D, enable table feeds enable
// - Three inputs, eight-bit truth table per table
// - Both tables share one set of inputs
// - Inputs count only on chosen level or edge
// - Write one row bit or whole word
// - Word bit n is row n, input 2 MSB
// - Output holds unless enable table output true
// - Enable table all ones passes value through
// - Block, table and input slot selectors
// - Input sources: zero, lines, users, counters, events
// - Five qualifiers: low, high, fall, rise, either
`ifndef LB_REGS_SVH
`define LB_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LB_OFS_SELECT 8'h00
`define LB_OFS_INPUT_CFG 8'h04
`define LB_OFS_ROW_BIT 8'h08
`define LB_OFS_TABLE_WORD 8'h0c
`define LB_OFS_STATUS 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LB_SEL_BLOCK_BIT 0
`define LB_SEL_TABLE_BIT 1
`define LB_SEL_SLOT_LSB 2
`define LB_SEL_SLOT_MSB 3
`define LB_SEL_ROW_LSB 4
`define LB_SEL_ROW_MSB 6
`define LB_CFG_SRC_LSB 0
`define LB_CFG_SRC_MSB 4
`define LB_CFG_QUAL_LSB 8
`define LB_CFG_QUAL_MSB 10

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define LB_NUM_BLOCKS 2
`define LB_NUM_INPUTS 3
`define LB_NUM_SOURCES 19
`define LB_TABLE_RESET 8'h00
`define LB_TABLE_ALL_ONES 8'hff

`endif

/* File: verif/lb_chk.sv */
// Bus and output checker for the logic block
`timescale 1ns/100ps
`default_nettype none
`include "lb_regs.svh"
module lb_chk (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [1:0] logic_block_out
);
    // ----------------------------------------------------------------
    // Clocking and bus phases
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // Setup cycle of a transfer
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    // Access cycle of a transfer
    sequence s_access;
        psel_in && penable_in;
    endsequence
    // Reads that complete, at any register address
    sequence s_read_done;
        pready_out && !pwrite_in;
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_one_wait;
        s_setup ##1 s_access |=> pready_out;
    endproperty
    property p_ready_cause;
        pready_out |-> psel_in && penable_in && $past(penable_in)
            && $past(psel_in, 2) && !$past(penable_in, 2);
    endproperty
    property p_ready_pulse;
        pready_out |=> !pready_out;
    endproperty
    property p_err_map;
        pready_out && paddr_in[1:0] == 2'b00
            |-> pslverr_out == (paddr_in > `LB_OFS_STATUS);
    endproperty
    property p_idle_quiet;
        !pready_out |-> !pslverr_out && prdata_out == 32'h00000000;
    endproperty
    property p_write_quiet;
        pready_out && pwrite_in |-> prdata_out == 32'h00000000;
    endproperty
    property p_cfg_spare;
        s_read_done and (paddr_in == `LB_OFS_INPUT_CFG)
            |-> prdata_out[31:11] == 21'h0 && prdata_out[7:5] == 3'h0;
    endproperty
    property p_word_spare;
        s_read_done and (paddr_in == `LB_OFS_TABLE_WORD)
            |-> prdata_out[31:8] == 24'h0;
    endproperty
    property p_reset_out;
        $past(!rst_n_in) |-> logic_block_out == 2'b00 && !pready_out;
    endproperty

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_one_wait: assert property (p_one_wait)
        else $error("pready missing after one wait state");
    a_ready_cause: assert property (p_ready_cause)
        else $error("pready without setup and two access cycles");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    a_err_map: assert property (p_err_map)
        else $error("slave error does not match address map");
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("read data or error outside pready cycle");
    a_write_quiet: assert property (p_write_quiet)
        else $error("read data driven during a write");
    a_cfg_spare: assert property (p_cfg_spare)
        else $error("input config spare bits not zero");
    a_word_spare: assert property (p_word_spare)
        else $error("truth word wider than eight bits");
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not clear after reset");
endmodule : lb_chk

bind lb_logic_block lb_chk u_chk (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .logic_block_out(logic_block_out)
);
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the logic block
`timescale 1ns/100ps
`default_nettype none
`include "lb_regs.svh"
module testbench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clock_in = 1'b0; // 250 MHz clock
    logic rst_n_in = 1'b0; // Async reset
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00; // Byte address
    logic [31:0] pwdata_in = 32'h0, prdata_out; // Bus data
    logic pready_out, pslverr_out; // Bus answer
    logic [18:1] src = '0; // Source levels, index is source code
    logic [1:0] logic_block_out; // Block outputs
    logic [31:0] seed = 32'hdfa30eb5, rd, v; // Random state, scratch
    logic err; // Error seen on last transfer
    int n_fail = 0, comparisons = 0, cycles = 0, cnt;

    always #2 clock_in = ~clock_in;

    lb_logic_block u_dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .line_in(src[4:1]),
        .user_output_in(src[8:5]), .counter_start_in(src[10:9]),
        .counter_end_in(src[12:11]), .exposure_start_in(src[15]),
        .exposure_end_in(src[16]), .frame_trigger_wait_in(src[17]),
        .acquisition_active_in(src[18]), .logic_block_out(logic_block_out)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Xorshift generator
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // High cycles of the output over the qualifier test window
    function automatic int qexp(input int q);
        case (q)
            0: return 10;
            1: return 5;
            4: return 2;
            5: return 0;
            default: return 1;
        endcase
    endfunction : qexp
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One bus transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        // Wait ends on pready; only the hang guard ends a wait that gets no answer
        do begin
            @(posedge clock_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    // Selector write: block, table, slot, row pointer
    task automatic sel(input int b, t, s, r);
        apb(1'b1, `LB_OFS_SELECT, 32'(b | t << 1 | s << 2 | r << 4));
    endtask : sel
    // Program a block: three sources, slot 0 qualifier, both tables
    task automatic prog(input int b, c0, c1, c2, q, input logic [7:0] vw,
                        input logic [7:0] ew);
        sel(b, 0, 2, 0);
        apb(1'b1, `LB_OFS_INPUT_CFG, 32'(c2 | 32'h100));
        sel(b, 0, 1, 0);
        apb(1'b1, `LB_OFS_INPUT_CFG, 32'(c1 | 32'h100));
        sel(b, 0, 0, 0);
        apb(1'b1, `LB_OFS_INPUT_CFG, 32'(c0 | q << 8));
        apb(1'b1, `LB_OFS_TABLE_WORD, {24'h0, vw});
        sel(b, 1, 0, 0);
        apb(1'b1, `LB_OFS_TABLE_WORD, {24'h0, ew});
    endtask : prog
    // Drive user lines 1..0 and check block 0 after settling
    task automatic step(input logic [1:0] u, input logic e);
        src[6:5] <= u;
        repeat (5) @(posedge clock_in);
        check(logic_block_out[0], e);
    endtask : step
    // Verdict
    task automatic tally_and_finish();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard
    always @(posedge clock_in) begin
        cycles++;
        if (cycles > 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        // Reset values, unmapped place, read-only status
        apb(1'b0, `LB_OFS_INPUT_CFG, 0);
        check(rd, 32'h100);
        apb(1'b0, `LB_OFS_TABLE_WORD, 0);
        check(rd, 32'h0);
        apb(1'b1, `LB_OFS_STATUS, 32'h3);
        apb(1'b0, `LB_OFS_STATUS, 0);
        check(rd, 32'h0);
        apb(1'b0, 8'h14, 0);
        check({rd[30:0], err}, 32'h1);
        // Random value tables, row order, enable all ones
        for (int b = 0; b < 2; b++) begin
            v = rnd() & 32'hff;
            prog(b, 5, 6, 7, 1, v[7:0], 8'hff);
            for (int r = 0; r < 8; r++) begin
                src[7:5] <= r[2:0];
                repeat (5) @(posedge clock_in);
                check(logic_block_out[b], v[r]);
            end
        end
        // Enable table read-back of the shared slot 2 setting
        sel(1, 1, 2, 0);
        apb(1'b0, `LB_OFS_INPUT_CFG, 0);
        check(rd, 32'h107);
        apb(1'b0, `LB_OFS_TABLE_WORD, 0);
        check(rd, 32'hff);
        // Single-row writes build the inverted word
        for (int r = 0; r < 8; r++) begin
            sel(1, 0, 0, r);
            apb(1'b1, `LB_OFS_ROW_BIT, {31'h0, ~v[r]});
        end
        apb(1'b0, `LB_OFS_TABLE_WORD, 0);
        check(rd, {24'h0, ~v[7:0]});
        // Reserved slot 3 keeps nothing
        sel(0, 0, 3, 0);
        apb(1'b1, `LB_OFS_INPUT_CFG, 32'h105);
        apb(1'b0, `LB_OFS_INPUT_CFG, 0);
        check(rd, 32'h0);
        // Latch: value on user 0, enable on user 1
        src <= '0;
        prog(0, 5, 6, 0, 1, 8'haa, 8'hcc);
        step(2'b11, 1'b1);
        step(2'b00, 1'b1);
        step(2'b10, 1'b0);
        step(2'b01, 1'b0);
        // Every qualifier on one five-cycle pulse
        for (int q = 0; q < 6; q++) begin
            src <= '0;
            prog(0, 5, 0, 0, q, 8'haa, 8'hff);
            repeat (6) @(posedge clock_in);
            cnt = 0;
            for (int i = 0; i < 15; i++) begin
                @(posedge clock_in);
                if (i == 0) src[5] <= 1'b1;
                if (i == 5) src[5] <= 1'b0;
                cnt += int'(logic_block_out[0]);
            end
            check(cnt, qexp(q));
        end
        // Every external source code at high level
        sel(0, 0, 0, 0);
        for (int c = 1; c < 19; c++) begin
            if (c != 13 && c != 14) begin
                apb(1'b1, `LB_OFS_INPUT_CFG, 32'(c | 32'h100));
                src[c] <= 1'b1;
                repeat (6) @(posedge clock_in);
                check(logic_block_out[0], 1'b1);
                src[c] <= 1'b0;
                repeat (6) @(posedge clock_in);
                check(logic_block_out[0], 1'b0);
            end
        end
        // Block 1 fed from block 0 output
        prog(1, 13, 0, 0, 1, 8'haa, 8'hff);
        sel(0, 0, 0, 0);
        apb(1'b1, `LB_OFS_INPUT_CFG, 32'h104);
        src[4] <= 1'b1;
        repeat (8) @(posedge clock_in);
        check(logic_block_out, 2'b11);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
